// file: rtl/tmoc_pkg.sv
`default_nettype none
package tmoc_pkg;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL_A  = 8'h00;
    localparam logic [7:0] ADDR_CTRL_B  = 8'h04;
    localparam logic [7:0] ADDR_COUNTER = 8'h08;
    localparam logic [7:0] ADDR_CMP_A   = 8'h0c;
    localparam logic [7:0] ADDR_CMP_B   = 8'h10;
    localparam logic [7:0] ADDR_FLAGS   = 8'h14;
    localparam logic [7:0] ADDR_MASK    = 8'h18;
    localparam logic [7:0] ADDR_PORT    = 8'h1c;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRLA_MODE_B_LSB = 4;   // compare_output_mode b, bits 5:4
    localparam int CTRLA_MODE_A_LSB = 6;   // compare_output_mode a, bits 7:6
    localparam int CTRLA_WGM_LSB    = 0;   // waveform_mode_select bits 1:0
    localparam int CTRLB_WGM2_BIT   = 3;   // waveform_mode_select bit 2
    localparam int CTRLB_RUN_BIT    = 0;   // counter clock enable
    localparam int CTRLB_FOCB_BIT   = 6;   // force_compare_strobe b
    localparam int CTRLB_FOCA_BIT   = 7;   // force_compare_strobe a
    localparam int FLAG_OVF_BIT     = 0;
    localparam int FLAG_CMPA_BIT    = 1;
    localparam int FLAG_CMPB_BIT    = 2;
    localparam int PORT_VAL_A_BIT   = 0;
    localparam int PORT_VAL_B_BIT   = 1;
    localparam int PORT_DIR_A_BIT   = 2;
    localparam int PORT_DIR_B_BIT   = 3;

    // ------------------------------------------------------------------
    // Reset values and counter limits
    // ------------------------------------------------------------------
    localparam logic [7:0] RESET_BYTE  = 8'h00;
    localparam logic [7:0] CNT_BOTTOM  = 8'h00;
    localparam logic [7:0] CNT_MAX     = 8'hff;
    localparam logic [7:0] CNT_ONE     = 8'h01;

    // ------------------------------------------------------------------
    // Waveform modes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        TMOC_WGM_NORMAL   = 3'b000,
        TMOC_WGM_PC_MAX   = 3'b001,
        TMOC_WGM_CTC      = 3'b010,
        TMOC_WGM_FAST_MAX = 3'b011,
        TMOC_WGM_RSV4     = 3'b100,
        TMOC_WGM_PC_OCRA  = 3'b101,
        TMOC_WGM_RSV6     = 3'b110,
        TMOC_WGM_FAST_OCR = 3'b111
    } tmoc_wgm_t;

    // Compare output actions.
    typedef enum logic [1:0] {
        TMOC_COM_OFF    = 2'b00,
        TMOC_COM_TOGGLE = 2'b01,
        TMOC_COM_CLEAR  = 2'b10,
        TMOC_COM_SET    = 2'b11
    } tmoc_com_t;

    // Per-channel pin pair towards the port.
    typedef struct packed {
        logic value;
        logic enable;
    } tmoc_pin_t;

endpackage

`default_nettype wire

// file: rtl/tmoc_timer.sv
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module tmoc_timer
    import tmoc_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        ovf_ack,
    input  wire logic        cmp_a_ack,
    input  wire logic        cmp_b_ack,
    output var  logic        ovf_irq,
    output var  logic        cmp_a_irq,
    output var  logic        cmp_b_irq,
    output var  tmoc_pin_t   pin_a,
    output var  tmoc_pin_t   pin_b
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [7:0] ctrl_a_q;
    logic [2:0] wgm_hi_q;
    logic       run_q;
    logic [7:0] counter_value_q;
    logic       down_q;
    logic [7:0] cmp_act_q [2];
    logic [7:0] cmp_buf_q [2];
    logic [1:0] cmp_flag_q;
    logic       overflow_flag_q;
    logic [2:0] mask_q;
    logic [3:0] port_q;
    logic [1:0] ocs_q;
    logic       blk_q;
    logic [1:0] match_q;

    // ------------------------------------------------------------------
    // Mode decoding
    // ------------------------------------------------------------------
    function automatic logic is_pwm(input tmoc_wgm_t m);
        is_pwm = (m == TMOC_WGM_PC_MAX) || (m == TMOC_WGM_PC_OCRA) ||
                 (m == TMOC_WGM_FAST_MAX) || (m == TMOC_WGM_FAST_OCR);
    endfunction

    function automatic logic is_pc(input tmoc_wgm_t m);
        is_pc = (m == TMOC_WGM_PC_MAX) || (m == TMOC_WGM_PC_OCRA);
    endfunction

    function automatic tmoc_com_t chan_mode(input logic [7:0] ca, input int ch);
        chan_mode = tmoc_com_t'(ch == 0 ? ca[CTRLA_MODE_A_LSB +: 2]
                                        : ca[CTRLA_MODE_B_LSB +: 2]);
    endfunction

    tmoc_wgm_t  wgm;
    logic       pwm;
    logic       pc;
    logic [7:0] top;
    logic       wr;
    logic       rd;
    logic       at_top;
    logic       at_bottom;
    logic [7:0] cnt_next;
    logic [1:0] eq;
    logic [1:0] hit;
    logic [1:0] force_hit;

    // Waveform mode is assembled from its two control registers.
    assign wgm = tmoc_wgm_t'({wgm_hi_q[CTRLB_WGM2_BIT - 1], ctrl_a_q[CTRLA_WGM_LSB +: 2]});
    assign pwm = is_pwm(wgm);
    assign pc  = is_pc(wgm);
    // Top is compare a in CTC and in the two PWM modes with compare a top, otherwise max.
    assign top = (wgm == TMOC_WGM_CTC || wgm == TMOC_WGM_PC_OCRA || wgm == TMOC_WGM_FAST_OCR)
               ? cmp_act_q[0] : CNT_MAX;
    assign wr  = psel && penable && pwrite;
    assign rd  = psel && penable && !pwrite;
    assign at_top    = (counter_value_q == top);
    assign at_bottom = (counter_value_q == CNT_BOTTOM);

    // ------------------------------------------------------------------
    // APB slave: one-cycle access, errors on unmapped addresses
    // ------------------------------------------------------------------
    logic mapped;
    always_comb begin
        if (paddr == ADDR_CTRL_A || paddr == ADDR_CTRL_B || paddr == ADDR_COUNTER) begin
            mapped = 1'b1;
        end else if (paddr == ADDR_CMP_A || paddr == ADDR_CMP_B) begin
            mapped = 1'b1;
        end else if (paddr == ADDR_FLAGS || paddr == ADDR_MASK || paddr == ADDR_PORT) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    // Ready answers in the first access cycle and falls after it.
    always_ff @(posedge clock) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
        end
    end

    // Read data is prepared during setup so it is valid with pready.
    always_ff @(posedge clock) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= 32'h0000_0000;
            if (paddr == ADDR_CTRL_A) begin
                prdata[7:0] <= ctrl_a_q;
            end else if (paddr == ADDR_CTRL_B) begin
                prdata[CTRLB_WGM2_BIT] <= wgm_hi_q[CTRLB_WGM2_BIT - 1];
                prdata[CTRLB_RUN_BIT]  <= run_q;
            end else if (paddr == ADDR_COUNTER) begin
                prdata[7:0] <= counter_value_q;
            end else if (paddr == ADDR_CMP_A) begin
                prdata[7:0] <= pwm ? cmp_buf_q[0] : cmp_act_q[0];
            end else if (paddr == ADDR_CMP_B) begin
                prdata[7:0] <= pwm ? cmp_buf_q[1] : cmp_act_q[1];
            end else if (paddr == ADDR_FLAGS) begin
                prdata[FLAG_OVF_BIT]  <= overflow_flag_q;
                prdata[FLAG_CMPA_BIT] <= cmp_flag_q[0];
                prdata[FLAG_CMPB_BIT] <= cmp_flag_q[1];
            end else if (paddr == ADDR_MASK) begin
                prdata[2:0] <= mask_q;
            end else if (paddr == ADDR_PORT) begin
                prdata[3:0] <= port_q;
            end
        end
    end

    // Control registers; mode bits act at once, not buffered.
    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_a_q <= RESET_BYTE;
            wgm_hi_q <= 3'b000;
            run_q    <= 1'b0;
            mask_q   <= 3'b000;
            port_q   <= 4'h0;
        end else if (wr) begin
            if (paddr == ADDR_CTRL_A) begin
                ctrl_a_q <= pwdata[7:0];
            end else if (paddr == ADDR_CTRL_B) begin
                wgm_hi_q <= {2'b00, pwdata[CTRLB_WGM2_BIT]} << 2;
                run_q    <= pwdata[CTRLB_RUN_BIT];
            end else if (paddr == ADDR_MASK) begin
                mask_q <= pwdata[2:0];
            end else if (paddr == ADDR_PORT) begin
                port_q <= pwdata[3:0];
            end
        end
    end

    // Force strobes are decoded from the write and never stored.
    assign force_hit[0] = wr && paddr == ADDR_CTRL_B && pwdata[CTRLB_FOCA_BIT] && !pwm;
    assign force_hit[1] = wr && paddr == ADDR_CTRL_B && pwdata[CTRLB_FOCB_BIT] && !pwm;

    // ------------------------------------------------------------------
    // Counter unit
    // ------------------------------------------------------------------
    // Next count follows the waveform mode, the count direction and the top value.
    always_comb begin
        cnt_next = counter_value_q;
        if (wgm == TMOC_WGM_NORMAL) begin
            cnt_next = counter_value_q + CNT_ONE;
        end else if (pc) begin
            if (down_q) begin
                cnt_next = at_bottom ? counter_value_q + CNT_ONE : counter_value_q - CNT_ONE;
            end else begin
                cnt_next = at_top ? counter_value_q - CNT_ONE : counter_value_q + CNT_ONE;
            end
        end else begin
            cnt_next = at_top ? CNT_BOTTOM : counter_value_q + CNT_ONE;
        end
    end

    // A CPU write overrides any count or clear in the same cycle.
    always_ff @(posedge clock) begin
        if (rst) begin
            counter_value_q <= CNT_BOTTOM;
            down_q          <= 1'b0;
        end else if (wr && paddr == ADDR_COUNTER) begin
            counter_value_q <= pwdata[7:0];
        end else if (run_q) begin
            counter_value_q <= cnt_next;
            if (!pc) begin
                down_q <= 1'b0;
            end else if (at_top && !down_q) begin
                down_q <= 1'b1;
            end else if (at_bottom && down_q) begin
                down_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Compare registers with double buffering
    // ------------------------------------------------------------------
    logic update_pt;
    // Fast PWM reloads at top, phase correct at top while counting up.
    assign update_pt = run_q && (pc ? (at_top && !down_q) : at_top);

    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_cmp
            localparam logic [7:0] ADDR_CH = (ch == 0) ? ADDR_CMP_A : ADDR_CMP_B;
            always_ff @(posedge clock) begin
                if (rst) begin
                    cmp_act_q[ch] <= RESET_BYTE;
                    cmp_buf_q[ch] <= RESET_BYTE;
                end else begin
                    if (wr && paddr == ADDR_CH) begin
                        cmp_buf_q[ch] <= pwdata[7:0];
                    end
                    if (wr && paddr == ADDR_CH && !pwm) begin
                        cmp_act_q[ch] <= pwdata[7:0];
                    end else if (pwm && update_pt) begin
                        cmp_act_q[ch] <= cmp_buf_q[ch];
                    end
                end
            end
            // Equality is always evaluated on the active value.
            assign eq[ch] = (counter_value_q == cmp_act_q[ch]);
        end
    endgenerate

    // ------------------------------------------------------------------
    // Match blocking and flags
    // ------------------------------------------------------------------
    // Block stays one cycle after any counter write.
    always_ff @(posedge clock) begin
        if (rst) begin
            blk_q <= 1'b0;
        end else begin
            blk_q <= wr && paddr == ADDR_COUNTER;
        end
    end

    assign hit = blk_q ? 2'b00 : eq;

    // Registered match so the flag sets on the following cycle.
    always_ff @(posedge clock) begin
        if (rst) begin
            match_q <= 2'b00;
        end else begin
            match_q <= hit & {2{run_q}};
        end
    end

    logic       flag_wr;
    logic       ovf_evt;
    assign flag_wr = wr && paddr == ADDR_FLAGS;
    // Overflow as the counter becomes zero, normal and CTC count up.
    assign ovf_evt = run_q && !(wr && paddr == ADDR_COUNTER) &&
                     (pc ? (at_bottom && down_q) : cnt_next == CNT_BOTTOM && !at_bottom);

    // A set arriving with a clear wins over it.
    always_ff @(posedge clock) begin
        if (rst) begin
            cmp_flag_q      <= 2'b00;
            overflow_flag_q <= 1'b0;
        end else begin
            for (int ch = 0; ch < 2; ch++) begin
                if (match_q[ch]) begin
                    cmp_flag_q[ch] <= 1'b1;
                end else if ((ch == 0 ? cmp_a_ack : cmp_b_ack) ||
                             (flag_wr && pwdata[FLAG_CMPA_BIT + ch])) begin
                    cmp_flag_q[ch] <= 1'b0;
                end
            end
            if (ovf_evt) begin
                overflow_flag_q <= 1'b1;
            end else if (ovf_ack || (flag_wr && pwdata[FLAG_OVF_BIT])) begin
                overflow_flag_q <= 1'b0;
            end
        end
    end

    // Interrupt requests follow flag and mask.
    always_ff @(posedge clock) begin
        if (rst) begin
            ovf_irq   <= 1'b0;
            cmp_a_irq <= 1'b0;
            cmp_b_irq <= 1'b0;
        end else begin
            ovf_irq   <= overflow_flag_q && mask_q[FLAG_OVF_BIT];
            cmp_a_irq <= cmp_flag_q[0] && mask_q[FLAG_CMPA_BIT];
            cmp_b_irq <= cmp_flag_q[1] && mask_q[FLAG_CMPB_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Waveform generator and output state
    // ------------------------------------------------------------------
    // Output state is untouched by mode changes; only events move it.
    always_ff @(posedge clock) begin
        if (rst) begin
            ocs_q <= 2'b00;
        end else begin
            for (int ch = 0; ch < 2; ch++) begin
                tmoc_com_t m;
                logic      ev;
                m  = chan_mode(ctrl_a_q, ch);
                ev = (hit[ch] && run_q) || force_hit[ch];
                if (m == TMOC_COM_OFF) begin
                    ocs_q[ch] <= ocs_q[ch];
                end else if (!pwm) begin
                    if (ev) begin
                        case (m)
                            TMOC_COM_TOGGLE: ocs_q[ch] <= !ocs_q[ch];
                            TMOC_COM_CLEAR:  ocs_q[ch] <= 1'b0;
                            default:         ocs_q[ch] <= 1'b1;
                        endcase
                    end
                end else if (m == TMOC_COM_TOGGLE) begin
                    if (ch == 0 && hit[ch] && run_q && wgm[2]) begin
                        ocs_q[ch] <= !ocs_q[ch];
                    end
                end else if (hit[ch] && run_q) begin
                    // Non-inverting clears on up match, inverting sets.
                    ocs_q[ch] <= (m == TMOC_COM_SET) ^ (pc && down_q);
                end else if (!pc && run_q && at_top) begin
                    ocs_q[ch] <= (m != TMOC_COM_SET);
                end
            end
        end
    end

    // Pin override registered straight from the output state.
    always_ff @(posedge clock) begin
        if (rst) begin
            pin_a <= '0;
            pin_b <= '0;
        end else begin
            pin_a.value  <= (chan_mode(ctrl_a_q, 0) != TMOC_COM_OFF)
                          ? ocs_q[0] : port_q[PORT_VAL_A_BIT];
            pin_a.enable <= port_q[PORT_DIR_A_BIT];
            pin_b.value  <= (chan_mode(ctrl_a_q, 1) != TMOC_COM_OFF)
                          ? ocs_q[1] : port_q[PORT_VAL_B_BIT];
            pin_b.enable <= port_q[PORT_DIR_B_BIT];
        end
    end

endmodule

`default_nettype wire

// file: bench/tmoc_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Port checker for the timer compare block.
// ------------------------------------------------------------
module tmoc_properties
    import tmoc_pkg::*;
(
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        ovf_ack,
    input wire logic        cmp_a_ack,
    input wire logic        cmp_b_ack,
    input wire logic        ovf_irq,
    input wire logic        cmp_a_irq,
    input wire logic        cmp_b_irq,
    input wire tmoc_pin_t   pin_a,
    input wire tmoc_pin_t   pin_b
);
    // All checks share the one clock and pause while reset is high.
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    // A transfer completes when the access phase meets ready.
    wire logic done = psel && penable && pready;

    property p_answer;
        psel && !penable |=> pready;
    endproperty
    a_answer: assert property (p_answer) else $error("no ready after setup");
    property p_pulse;
        pready |=> !pready;
    endproperty
    a_pulse: assert property (p_pulse) else $error("ready held too long");
    property p_decode;
        done |-> pslverr == (paddr[1:0] != 2'b00 || paddr > ADDR_PORT);
    endproperty
    a_decode: assert property (p_decode) else $error("bad error response");
    property p_upper;
        done && !pwrite |-> prdata[31:8] == 24'h0;
    endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_quiet;
        $fell(rst) |-> !pready && !ovf_irq && !cmp_a_irq && !cmp_b_irq
            && pin_a == 2'b00 && pin_b == 2'b00;
    endproperty
    a_quiet: assert property (p_quiet) else $error("outputs active after reset");
    property p_ack;
        (cmp_a_ack |-> ##2 !cmp_a_irq) and (cmp_b_ack |-> ##2 !cmp_b_irq);
    endproperty
    a_ack: assert property (p_ack) else $error("compare request not cleared");
    property p_ovf_clear;
        ovf_ack || (done && pwrite && paddr == ADDR_FLAGS && pwdata[FLAG_OVF_BIT])
            |-> ##2 !ovf_irq;
    endproperty
    a_ovf_clear: assert property (p_ovf_clear) else $error("overflow not cleared");
    property p_dir;
        done && pwrite && paddr == ADDR_PORT |-> ##2
            pin_a.enable == $past(pwdata[PORT_DIR_A_BIT], 2)
            && pin_b.enable == $past(pwdata[PORT_DIR_B_BIT], 2);
    endproperty
    a_dir: assert property (p_dir) else $error("pin direction wrong");
endmodule
`default_nettype wire

// file: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Testbench for the timer compare block.
// ------------------------------------------------------------
module tb
    import tmoc_pkg::*;
;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  acks = 3'h0;
    logic [2:0]  irqs;
    tmoc_pin_t   pin_a;
    tmoc_pin_t   pin_b;
    logic [31:0] rd;
    logic        err;
    int          mismatches = 0;
    int          compares = 0;
    tmoc_com_t   modes [4] = '{TMOC_COM_SET, TMOC_COM_CLEAR, TMOC_COM_TOGGLE, TMOC_COM_TOGGLE};
    logic [3:0]  exp_v = 4'h5;

    // Device under test.
    tmoc_timer u_tmoc_timer (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ovf_ack(acks[0]), .cmp_a_ack(acks[1]), .cmp_b_ack(acks[2]),
        .ovf_irq(irqs[0]), .cmp_a_irq(irqs[1]), .cmp_b_irq(irqs[2]), .pin_a(pin_a),
        .pin_b(pin_b));

    // Clock generator and hang watchdog.
    initial begin
        forever #25 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        end_of_test();
    end

    // Compare one value and count the outcome.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // One bus transfer; the request holds until ready is sampled high.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
        if (n >= 16) begin
            mismatches++;
            end_of_test();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // Wait a bounded time for one request line.
    task automatic wait_irq(input int s);
        int n;
        n = 0;
        while (irqs[s] !== 1'b1 && n < 40) begin
            @(posedge clock);
            n++;
        end
        chk({31'h0, irqs[s]}, 32'h1);
        // A request that never came has been counted; stop the run here.
        if (irqs[s] !== 1'b1) begin
            end_of_test();
        end
    endtask

    task automatic pulse(input int s);
        acks[s] <= 1'b1;
        @(posedge clock);
        acks[s] <= 1'b0;
        @(posedge clock);
    endtask

    // Let the pin registers settle, then compare a pin pair.
    task automatic pchk(input logic b, input logic [1:0] exp);
        repeat (3) @(posedge clock);
        chk({30'h0, b ? pin_b : pin_a}, {30'h0, exp});
    endtask

    // Main sequence.
    initial begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rdc(8'(i * 4), 32'h0);
        end
        rdc(8'h22, 32'h0);
        chk({31'h0, err}, 32'h1);
        wr(8'h24, 32'hff);
        $display("test reset and decode done");
        wr(ADDR_MASK, 32'h3);
        wr(ADDR_CMP_A, 32'h01);
        wr(ADDR_CMP_B, 32'h80);
        wr(ADDR_COUNTER, 32'hfe);
        wr(ADDR_CTRL_B, 32'h1);
        wait_irq(0);
        wait_irq(1);
        wr(ADDR_CTRL_B, 32'h0);
        rdc(ADDR_FLAGS, 32'h3);
        pulse(0);
        rdc(ADDR_FLAGS, 32'h2);
        wr(ADDR_FLAGS, 32'h3);
        rdc(ADDR_FLAGS, 32'h0);
        chk({29'h0, irqs}, 32'h0);
        $display("test overflow and flags done");
        wr(ADDR_MASK, 32'h7);
        wr(ADDR_CMP_B, 32'h40);
        wr(ADDR_CTRL_B, 32'h1);
        wr(ADDR_COUNTER, 32'h40);
        repeat (8) @(posedge clock);
        rdc(ADDR_FLAGS, 32'h0);
        wr(ADDR_COUNTER, 32'h3e);
        wait_irq(2);
        wr(ADDR_CTRL_B, 32'h0);
        pulse(2);
        rdc(ADDR_FLAGS, 32'h0);
        $display("test match blocking done");
        wr(ADDR_CTRL_A, 32'hc0);
        wr(ADDR_CTRL_B, 32'h80);
        wr(ADDR_PORT, 32'hc);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CTRL_A, 32'(modes[i]) << CTRLA_MODE_A_LSB);
            wr(ADDR_CTRL_B, 32'h80);
            pchk(1'b0, {exp_v[i], 1'b1});
        end
        rdc(ADDR_CTRL_B, 32'h0);
        rdc(ADDR_FLAGS, 32'h0);
        wr(ADDR_CTRL_A, 32'h0);
        wr(ADDR_PORT, 32'hd);
        pchk(1'b0, 2'b11);
        wr(ADDR_CTRL_B, 32'h80);
        wr(ADDR_CTRL_A, 32'h40);
        pchk(1'b0, 2'b01);
        wr(ADDR_CTRL_A, 32'h43);
        pchk(1'b0, 2'b01);
        wr(ADDR_CTRL_B, 32'h80);
        pchk(1'b0, 2'b01);
        wr(ADDR_CTRL_A, 32'h30);
        wr(ADDR_CTRL_B, 32'h40);
        pchk(1'b1, 2'b11);
        wr(ADDR_PORT, 32'h0);
        pchk(1'b1, 2'b10);
        $display("test output modes done");
        wr(ADDR_CTRL_A, 32'h0);
        wr(ADDR_CMP_A, 32'h10);
        wr(ADDR_CTRL_A, 32'h3);
        wr(ADDR_CMP_A, 32'h90);
        rdc(ADDR_CMP_A, 32'h90);
        wr(ADDR_COUNTER, 32'h0c);
        wr(ADDR_CTRL_B, 32'h1);
        wait_irq(1);
        wr(ADDR_CTRL_B, 32'h0);
        pulse(1);
        rdc(ADDR_FLAGS, 32'h0);
        wr(ADDR_CMP_A, 32'h02);
        wr(ADDR_COUNTER, 32'hfc);
        wr(ADDR_CTRL_B, 32'h1);
        wait_irq(1);
        wr(ADDR_CTRL_B, 32'h0);
        $display("test buffering done");
        end_of_test();
    end
endmodule

// Attach the port checker to every timer instance.
bind tmoc_timer tmoc_properties u_tmoc_properties (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ovf_ack(ovf_ack), .cmp_a_ack(cmp_a_ack),
    .cmp_b_ack(cmp_b_ack), .ovf_irq(ovf_irq), .cmp_a_irq(cmp_a_irq),
    .cmp_b_irq(cmp_b_irq), .pin_a(pin_a), .pin_b(pin_b));
`default_nettype wire
